// ---- rtl/clk_ctrl_pkg.sv ----
// Constants, state encodings and the code-to-factor map of the
// system clock divider. Shared by the top module and its helpers.
package clk_ctrl_pkg;
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 8;
    localparam int          CODE_W         = 4;
    localparam int          CNT_W          = 8;
    localparam int          LEFT_W         = 3;
    localparam logic [7:0]  TRIM_ADDR      = 8'h00;
    localparam logic [7:0]  DIVCTL_ADDR    = 8'h01;
    localparam int          UNLOCK_POS     = 7;
    localparam int          RANGE_POS      = 7;
    localparam logic [7:0]  UNLOCK_PATTERN = 8'h80;
    localparam logic [2:0]  UNUSED_BITS    = 3'h0;
    localparam logic [3:0]  CODE_UNDIVIDED = 4'h0;
    localparam logic [3:0]  CODE_RST_DIV8  = 4'h3;
    localparam logic [3:0]  CODE_MAX       = 4'h8;
    localparam logic [2:0]  UNLOCK_CYCLES  = 3'h4;
    localparam logic [7:0]  READ_IDLE      = 8'h00;

    typedef enum logic [2:0] {
        SW_IDLE      = 3'b001,
        SW_WAIT_OLD  = 3'b010,
        SW_FIRST_NEW = 3'b100
    } switch_state_t;

    // Reserved codes above the largest one divide like the largest
    function automatic logic [8:0] factor_of(input logic [3:0] code);
        logic [3:0] n;
        n = (code > CODE_MAX) ? CODE_MAX : code;
        return 9'h001 << n;
    endfunction
endpackage

// ---- rtl/div_ripple_counter.sv ----
// Prescaler counter on the undivided master clock.
// Assumes the applied code changes only in a cycle where tick is high,
// except in reset, where a count past the new end ends the period early.
`timescale 1ns/1ps
module div_ripple_counter
    import clk_ctrl_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic [CODE_W-1:0] code,
    output logic                   tick,
    output logic                   phase
);
    logic [8:0]       fac;
    logic [CNT_W-1:0] mask;
    logic [CNT_W-1:0] half;
    logic [CNT_W-1:0] nxt_cnt;
    logic [CNT_W-1:0] cnt_ff;
    logic [2:0]       warm_ff;
    logic             phase_ff;

    always_comb begin
        fac     = factor_of(code);
        mask    = CNT_W'(fac - 9'h001);
        half    = fac[8:1];
        // At or past the end: a reset-time code change must not wrap
        tick    = (cnt_ff >= mask);
        nxt_cnt = tick ? '0 : cnt_ff + 8'h01;
    end

    // Keeps counting through reset so the exported clock never stops.
    // The clear spans three reset edges so the synchronised fuse has
    // settled the code before the first count.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            warm_ff <= {warm_ff[1:0], 1'b1};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (warm_ff[2]) begin
            cnt_ff <= nxt_cnt;
        end else begin
            cnt_ff <= '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (warm_ff[2]) begin
            phase_ff <= (nxt_cnt < half);
        end else begin
            phase_ff <= 1'b0;
        end
    end

    assign phase = phase_ff;
endmodule

// ---- rtl/unlock_window.sv ----
// Timed window that guards writes to the division code.
// Assumes tick marks one core clock cycle.
`timescale 1ns/1ps
module unlock_window
    import clk_ctrl_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              arm,
    input  wire logic              close,
    input  wire logic              tick,
    output logic                   open,
    output logic [LEFT_W-1:0]      left
);
    logic              open_ff;
    logic [LEFT_W-1:0] left_ff;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            open_ff <= 1'b0;
            left_ff <= '0;
        end else if (close) begin
            open_ff <= 1'b0;
            left_ff <= '0;
        end else if (arm && !open_ff) begin
            open_ff <= 1'b1;
            left_ff <= UNLOCK_CYCLES;
        end else if (open_ff && tick) begin
            // A repeated arm lands here: no restart, no clear
            left_ff <= left_ff - 3'h1;
            if (left_ff == 3'h1) begin
                open_ff <= 1'b0;
            end
        end
    end

    assign open = open_ff;
    assign left = left_ff;
endmodule

// ---- rtl/system_clock_divider_and_trim.sv ----
// System clock divider, unlock sequence, oscillator trim, clock export.
// Runs on the undivided master clock; fuses arrive as async levels.
//
// How it works
// - Export fuse puts clock on output pin.
// - Clock keeps driving pin during reset.
// - Pin carries divided clock; the source itself at divide by one.
// - One factor for all four clock domains.
// - Division changes outside reset never shorten a clock period.
// - No intermediate frequency above old or new.
// - New rate after two edges, bounded time.
// - Counter runs undivided, count hidden from software.
// - Unlock only when other bits written zero.
// - Unlock clears after four cycles or code.
// - Re-unlock neither restarts nor clears window.
// - Reset code follows divide-by-eight fuse.
// - Any code accepted after valid unlock.
// - Code n divides by two to n, up to 256.
// - Reset loads factory calibration into trim.
// - Trim writable anytime, drives oscillator directly.
// - Trim top bit picks overlapping range.
// - Low trim bits tune monotonically within range.
`timescale 1ns/1ps
module system_clock_divider_and_trim
    import clk_ctrl_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              write_strobe,
    input  wire logic              read_strobe,
    output logic      [DATA_W-1:0] rdata,
    input  wire logic              clock_export_fuse,
    input  wire logic              divide_by_eight_fuse,
    input  wire logic [DATA_W-1:0] factory_trim,
    input  wire logic              port_pin_out,
    input  wire logic              port_pin_oe,
    output logic                   clock_out_pin_out,
    output logic                   clock_out_pin_oe,
    output logic                   io_domain_clock_en,
    output logic                   converter_domain_clock_en,
    output logic                   core_domain_clock_en,
    output logic                   program_memory_clock_en,
    output logic                   trim_range_select,
    output logic      [6:0]        trim_fine_value,
    output logic                   switch_busy
);
    logic                exp_s1_ff;
    logic                exp_s2_ff;
    logic                d8_s1_ff;
    logic                d8_s2_ff;
    logic [DATA_W-1:0]   trim_ff;
    logic [CODE_W-1:0]   code_ff;
    logic [CODE_W-1:0]   applied_ff;
    logic [CODE_W-1:0]   rst_code;
    logic [DATA_W-1:0]   rdata_ff;
    switch_state_t       sw_state_ff;
    logic                wr_trim;
    logic                wr_div;
    logic                unlock_req;
    logic                code_wr;
    logic                unlock_open;
    logic [LEFT_W-1:0]   unlock_left;
    logic                tick;
    logic                phase;
    logic                clk_level;

    // Fuse levels come from outside the clock domain
    always_ff @(posedge clk_sys) begin
        exp_s1_ff <= clock_export_fuse;
        exp_s2_ff <= exp_s1_ff;
    end

    always_ff @(posedge clk_sys) begin
        d8_s1_ff <= divide_by_eight_fuse;
        d8_s2_ff <= d8_s1_ff;
    end

    // Register decode
    assign wr_trim    = write_strobe && (addr == TRIM_ADDR);
    assign wr_div     = write_strobe && (addr == DIVCTL_ADDR);
    assign unlock_req = wr_div && (wdata == UNLOCK_PATTERN);
    assign code_wr    = wr_div && !wdata[UNLOCK_POS] && unlock_open;
    assign rst_code   = d8_s2_ff ? CODE_RST_DIV8 : CODE_UNDIVIDED;

    unlock_window u_unlock (
        .clk_sys (clk_sys),
        .reset   (reset),
        .arm     (unlock_req),
        .close   (code_wr),
        .tick    (tick),
        .open    (unlock_open),
        .left    (unlock_left)
    );

    // Trim reaches the oscillator straight from the register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            trim_ff <= factory_trim;
        end else if (wr_trim) begin
            trim_ff <= wdata;
        end
    end

    assign trim_range_select = trim_ff[RANGE_POS];
    assign trim_fine_value   = trim_ff[6:0];

    // Programmed code; reserved values are stored as written
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            code_ff <= rst_code;
        end else if (code_wr) begin
            code_ff <= wdata[CODE_W-1:0];
        end
    end

    // Outside reset, applied code moves only at the end of a full old period
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            applied_ff <= rst_code;
        end else if (sw_state_ff == SW_WAIT_OLD && tick) begin
            applied_ff <= code_ff;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sw_state_ff <= SW_IDLE;
        end else begin
            case (sw_state_ff)
                SW_IDLE: begin
                    if (code_wr) begin
                        sw_state_ff <= SW_WAIT_OLD;
                    end
                end
                SW_WAIT_OLD: begin
                    if (code_wr) begin
                        sw_state_ff <= SW_WAIT_OLD;
                    end else if (tick) begin
                        sw_state_ff <= SW_FIRST_NEW;
                    end
                end
                SW_FIRST_NEW: begin
                    if (code_wr) begin
                        sw_state_ff <= SW_WAIT_OLD;
                    end else if (tick) begin
                        sw_state_ff <= SW_IDLE;
                    end
                end
                default: begin
                    sw_state_ff <= SW_IDLE;
                end
            endcase
        end
    end

    assign switch_busy = (sw_state_ff != SW_IDLE);

    div_ripple_counter u_counter (
        .clk_sys (clk_sys),
        .reset   (reset),
        .code    (applied_ff),
        .tick    (tick),
        .phase   (phase)
    );

    // One enable for every synchronous domain
    assign io_domain_clock_en        = tick;
    assign converter_domain_clock_en = tick;
    assign core_domain_clock_en      = tick;
    assign program_memory_clock_en   = tick;

    // Divide by one has no slower phase, so the source is passed on
    assign clk_level = (applied_ff == CODE_UNDIVIDED) ? clk_sys : phase;

    // Not gated by reset: the pin keeps toggling while reset holds
    assign clock_out_pin_out = exp_s2_ff ? clk_level : port_pin_out;
    assign clock_out_pin_oe  = exp_s2_ff ? 1'b1 : port_pin_oe;

    // Read data for one cycle; the counter itself is never readable
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_ff <= READ_IDLE;
        end else if (read_strobe) begin
            case (addr)
                TRIM_ADDR: begin
                    rdata_ff <= trim_ff;
                end
                DIVCTL_ADDR: begin
                    rdata_ff <= {unlock_open, UNUSED_BITS, code_ff};
                end
                default: begin
                    rdata_ff <= READ_IDLE;
                end
            endcase
        end else begin
            rdata_ff <= READ_IDLE;
        end
    end

    assign rdata = rdata_ff;

    // Checking helpers: length of each divided period
    logic [8:0] gap_ff;
    logic       gap_ok_ff;

    always_ff @(posedge clk_sys) begin
        if (tick) begin
            gap_ff <= 9'h000;
        end else begin
            gap_ff <= gap_ff + 9'h001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            gap_ok_ff <= 1'b0;
        end else if (tick) begin
            gap_ok_ff <= 1'b1;
        end
    end

    default clocking cb_sys @(posedge clk_sys);
    endclocking

    default disable iff (reset);

    sequence s_old_edge;
        sw_state_ff == SW_WAIT_OLD && tick && !code_wr;
    endsequence

    sequence s_applied;
        applied_ff == $past(code_ff) && sw_state_ff == SW_FIRST_NEW;
    endsequence

    property p_export;
        exp_s2_ff |-> clock_out_pin_oe;
    endproperty
    a_export: assert property (p_export)
        else $error("clock pin not driven with export fuse set");

    property p_out_in_reset;
        disable iff (1'b0)
        reset && exp_s2_ff && applied_ff != CODE_UNDIVIDED
            |-> clock_out_pin_oe && clock_out_pin_out == phase;
    endproperty
    a_out_in_reset: assert property (p_out_in_reset)
        else $error("clock pin lost during reset");

    property p_divided_out;
        exp_s2_ff && applied_ff != CODE_UNDIVIDED
            |-> clock_out_pin_out == phase;
    endproperty
    a_divided_out: assert property (p_divided_out)
        else $error("clock pin not showing divided clock");

    property p_domains;
        io_domain_clock_en == core_domain_clock_en
            && converter_domain_clock_en == core_domain_clock_en
            && program_memory_clock_en == core_domain_clock_en;
    endproperty
    a_domains: assert property (p_domains)
        else $error("clock domains divided differently");

    property p_full_period;
        tick && gap_ok_ff
            |-> (gap_ff + 9'h001) == factor_of(applied_ff);
    endproperty
    a_full_period: assert property (p_full_period)
        else $error("divided period shortened or stretched");

    property p_switch_time;
        code_wr |=> ##[0:256] s_old_edge ##1 s_applied;
    endproperty
    a_switch_time: assert property (p_switch_time)
        else $error("new division not applied in time");

    property p_unlock_set;
        unlock_req && !unlock_open
            |=> unlock_open && unlock_left == UNLOCK_CYCLES;
    endproperty
    a_unlock_set: assert property (p_unlock_set)
        else $error("valid unlock write not accepted");

    property p_unlock_bad;
        wr_div && wdata[UNLOCK_POS] && wdata != UNLOCK_PATTERN
            && !unlock_open |=> !unlock_open;
    endproperty
    a_unlock_bad: assert property (p_unlock_bad)
        else $error("unlock set by a write with other bits");

    property p_unlock_expire;
        unlock_open && tick && unlock_left == 3'h1 && !code_wr
            |=> !unlock_open;
    endproperty
    a_unlock_expire: assert property (p_unlock_expire)
        else $error("unlock window outlived four cycles");

    property p_code_close;
        code_wr |=> !unlock_open
            && code_ff == $past(wdata[CODE_W-1:0]);
    endproperty
    a_code_close: assert property (p_code_close)
        else $error("code write not taken or unlock not closed");

    property p_rearm;
        unlock_req && unlock_open && !tick
            |=> unlock_open && unlock_left == $past(unlock_left);
    endproperty
    a_rearm: assert property (p_rearm)
        else $error("repeated unlock changed the window");

    property p_reset_code;
        $fell(reset) |-> code_ff == ($past(d8_s2_ff) ? CODE_RST_DIV8
                                                     : CODE_UNDIVIDED);
    endproperty
    a_reset_code: assert property (p_reset_code)
        else $error("reset code does not follow fuse");

    property p_reset_trim;
        $fell(reset) |-> trim_ff == $past(factory_trim);
    endproperty
    a_reset_trim: assert property (p_reset_trim)
        else $error("calibration value not loaded at reset");

    property p_trim_write;
        wr_trim |=> trim_range_select == $past(wdata[RANGE_POS])
            && trim_fine_value == $past(wdata[6:0]);
    endproperty
    a_trim_write: assert property (p_trim_write)
        else $error("trim write not passed to oscillator");

    property p_readback;
        read_strobe && addr == DIVCTL_ADDR
            |=> rdata[6:4] == UNUSED_BITS
            && rdata[CODE_W-1:0] == $past(code_ff);
    endproperty
    a_readback: assert property (p_readback)
        else $error("control register read back wrong");
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the system clock divider and trim block.
// Drives the register port, fuses and shared pin directly; no partner.
`timescale 1ns/1ps
module tb_top;
    import clk_ctrl_pkg::*;
    logic              clk_sys;
    logic              reset;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              write_strobe;
    logic              read_strobe;
    logic [DATA_W-1:0] rdata;
    logic              clock_export_fuse;
    logic              divide_by_eight_fuse;
    logic [DATA_W-1:0] factory_trim;
    logic              port_pin_out;
    logic              port_pin_oe;
    logic              clock_out_pin_out;
    logic              clock_out_pin_oe;
    logic              io_domain_clock_en;
    logic              converter_domain_clock_en;
    logic              core_domain_clock_en;
    logic              program_memory_clock_en;
    logic              trim_range_select;
    logic [6:0]        trim_fine_value;
    logic              switch_busy;
    int                n_mismatch = 0;
    int                n_compared = 0;
    int                gap = 1;
    int                last_gap = 0;
    int                pulses = 0;
    int                cur;
    int                r;
    logic [7:0]        trims [4] = '{8'h7F, 8'h80, 8'h00, 8'hFF};

    system_clock_divider_and_trim dut_u (
        .clk_sys                   (clk_sys),
        .reset                     (reset),
        .addr                      (addr),
        .wdata                     (wdata),
        .write_strobe              (write_strobe),
        .read_strobe               (read_strobe),
        .rdata                     (rdata),
        .clock_export_fuse         (clock_export_fuse),
        .divide_by_eight_fuse      (divide_by_eight_fuse),
        .factory_trim              (factory_trim),
        .port_pin_out              (port_pin_out),
        .port_pin_oe               (port_pin_oe),
        .clock_out_pin_out         (clock_out_pin_out),
        .clock_out_pin_oe          (clock_out_pin_oe),
        .io_domain_clock_en        (io_domain_clock_en),
        .converter_domain_clock_en (converter_domain_clock_en),
        .core_domain_clock_en      (core_domain_clock_en),
        .program_memory_clock_en   (program_memory_clock_en),
        .trim_range_select         (trim_range_select),
        .trim_fine_value           (trim_fine_value),
        .switch_busy               (switch_busy)
    );

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Enables are sampled mid-cycle so the counter flop has settled
    always @(negedge clk_sys) begin
        if (core_domain_clock_en === 1'b1) begin
            last_gap = gap;
            gap = 1;
            pulses = pulses + 1;
        end else begin
            gap = gap + 1;
        end
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] expd);
        n_compared++;
        if (seen !== expd) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                     expd);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr         <= a;
        wdata        <= d;
        write_strobe <= 1'b1;
        read_strobe  <= 1'b0;
    endtask

    task automatic idle();
        @(posedge clk_sys);
        write_strobe <= 1'b0;
        read_strobe  <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        addr         <= a;
        write_strobe <= 1'b0;
        read_strobe  <= 1'b1;
        idle();
        @(negedge clk_sys);
        chk(rdata, e);
    endtask

    task automatic count_rises(input int n, output int rises);
        logic prev;
        rises = 0;
        @(negedge clk_sys);
        prev = clock_out_pin_out;
        repeat (n) begin
            @(negedge clk_sys);
            if (clock_out_pin_out === 1'b1 && prev === 1'b0) rises++;
            prev = clock_out_pin_out;
        end
    endtask

    // Two-step change; old factor t1 lets the bench check the seam
    task automatic change(input logic [3:0] c, input int t1);
        int p0;
        int tw;
        int g1;
        int f;
        f = 1 << ((c > CODE_MAX) ? 8 : c);
        wr(DIVCTL_ADDR, UNLOCK_PATTERN);
        wr(DIVCTL_ADDR, {4'h7, c});
        idle();
        p0 = pulses;
        tw = 0;
        g1 = 0;
        while (pulses < p0 + 2 && tw < 1200) begin
            @(negedge clk_sys);
            #1;
            tw++;
            if (pulses == p0 + 1 && g1 == 0) g1 = last_gap;
            if (tw == 1) chk(switch_busy, 1'b1);
            chk({io_domain_clock_en, converter_domain_clock_en,
                 program_memory_clock_en}, {3{core_domain_clock_en}});
        end
        chk(g1, t1);
        chk(last_gap, f);
        chk(tw <= t1 + f && tw >= f, 1'b1);
        tw = 0;
        while (switch_busy !== 1'b0 && tw < 600) begin
            @(negedge clk_sys);
            tw++;
        end
        chk(switch_busy, 1'b0);
        rdchk(DIVCTL_ADDR, {4'h0, c});
        p0 = pulses;
        while (pulses < p0 + 2 && tw < 1200) begin
            @(negedge clk_sys);
            #1;
            tw++;
        end
        chk(last_gap, f);
    endtask

    initial begin
        repeat (60000) @(posedge clk_sys);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        reset                = 1'b1;
        addr                 = 8'h00;
        wdata                = 8'h00;
        write_strobe         = 1'b0;
        read_strobe          = 1'b0;
        clock_export_fuse    = 1'b0;
        divide_by_eight_fuse = 1'b0;
        factory_trim         = 8'hA5;
        port_pin_out         = 1'b1;
        port_pin_oe          = 1'b0;
        // Three edges so the fuse synchronisers settle before release
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        rdchk(TRIM_ADDR, 8'hA5);
        rdchk(DIVCTL_ADDR, 8'h00);
        rdchk(8'h02, 8'h00);
        $display("test reset done");
        // No memory writes run here, so the full trim range is allowed
        foreach (trims[i]) begin
            wr(TRIM_ADDR, trims[i]);
            wr(8'h02, 8'h5A);
            idle();
            chk(trim_range_select, trims[i][7]);
            chk(trim_fine_value, trims[i][6:0]);
            rdchk(TRIM_ADDR, trims[i]);
        end
        $display("test trim done");
        @(posedge clk_sys);
        chk({clock_out_pin_out, clock_out_pin_oe}, 2'b10);
        port_pin_out <= 1'b0;
        port_pin_oe  <= 1'b1;
        @(negedge clk_sys);
        chk({clock_out_pin_out, clock_out_pin_oe}, 2'b01);
        $display("test port pin done");
        cur = 1;
        for (int c = 1; c <= 9; c++) begin
            change(c[3:0], cur);
            cur = 1 << ((c > 8) ? 8 : c);
        end
        change(4'h0, cur);
        change(4'h4, 1);
        $display("test division done");
        wr(DIVCTL_ADDR, UNLOCK_PATTERN);
        idle();
        repeat (22) @(posedge clk_sys);
        wr(DIVCTL_ADDR, UNLOCK_PATTERN);
        idle();
        rdchk(DIVCTL_ADDR, 8'h84);
        repeat (42) @(posedge clk_sys);
        rdchk(DIVCTL_ADDR, 8'h04);
        wr(DIVCTL_ADDR, 8'h05);
        idle();
        rdchk(DIVCTL_ADDR, 8'h04);
        wr(DIVCTL_ADDR, 8'h81);
        wr(DIVCTL_ADDR, 8'h05);
        idle();
        rdchk(DIVCTL_ADDR, 8'h04);
        $display("test unlock done");
        @(posedge clk_sys);
        clock_export_fuse <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk(clock_out_pin_oe, 1'b1);
        count_rises(128, r);
        chk(r, 8);
        @(posedge clk_sys);
        divide_by_eight_fuse <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b1;
        count_rises(48, r);
        chk(r > 0, 1'b1);
        @(posedge clk_sys);
        reset <= 1'b0;
        rdchk(DIVCTL_ADDR, 8'h03);
        rdchk(TRIM_ADDR, 8'hA5);
        change(4'h0, 8);
        $display("test export done");
        report_and_stop();
    end
endmodule
